// >>> acs_consts.svh
// Constants, register map and timing counts of the conversion sequencer
// Behaviour
// R1 - Software keeps converter enable at 0 before using software-trigger wait mode.
// R2 - Start bit set while stopped in scan mode converts the four selected channels.
// R3 - Scan converts slot 0 first and proceeds in order through slot 3.
// R4 - Each finished scan conversion loads its own channel result register at once.
// R5 - Scan raises the conversion-end interrupt once, right after the fourth conversion.
// R6 - One-shot scan clears the start bit itself at the end and stops.
// R7 - Writing start bit 1 during conversion aborts, drops data and restarts.
// R8 - Channel select write during scan aborts and restarts from the new slot 0.
// R9 - Clearing start bit during wait-mode conversion aborts and stops the converter.
// R10 - Wait mode ignores hardware triggers while converting.
// R11 - Wait-mode restart begins after stabilization wait from the next conversion clock.
// R12 - First conversion after restart takes the time of one with stabilization wait.
// R13 - No-wait mode: enable bit set while stopped enters standby.
// R14 - Software waits one microsecond plus two clocks after enable before start.
// R15 - No-wait mode: start bit only arms trigger standby, no conversion yet.
// R16 - Trigger with start bit 1 converts the single selected channel.
// R17 - Sequential mode stores, interrupts and immediately converts the same channel again.
// R18 - No-wait mode: trigger during conversion aborts, drops data and restarts.
// R19 - No-wait mode: select write during conversion aborts and converts the new input.
// R20 - No-wait mode: clearing start aborts and returns to standby, still powered.
// R21 - Clearing enable in standby puts the converter into stop.
// R22 - With start bit 0 hardware triggers are ignored.
// R23 - No-wait abort restarts from the next conversion clock edge.
// R24 - An aborted conversion leaves the result registers at their old values.
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

`define ACS_A_CTRL 8'h00
`define ACS_A_SEL 8'h04
`define ACS_A_STAT 8'h08
`define ACS_A_RES0 8'h10
`define ACS_A_RES1 8'h14
`define ACS_A_RES2 8'h18
`define ACS_A_RES3 8'h1c
`define ACS_A_RES 8'h20

`define ACS_B_EN 0
`define ACS_B_START 1
`define ACS_B_HWMODE 2
`define ACS_B_SEQ 3

`define ACS_CONV_CYC 8'h10
`define ACS_STAB_NS 1000
`define ACS_CLK_NS 5
`define ACS_STAB_CYC (8'((`ACS_STAB_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS) + 8'h02)
`define ACS_RES_W 12

`endif

// >>> acs_pkg.sv
// Types of the conversion sequencer
package acs_pkg;
   typedef enum logic [3:0]
   {
      ACS_STOP = 4'h1,
      ACS_STBY = 4'h2,
      ACS_STAB = 4'h4,
      ACS_CONV = 4'h8
   } acs_state_t;
endpackage

// >>> acs_conv_timer.sv
// Conversion time counter: first conversion after a wait-mode start or any abort restart adds the stabilization wait
`timescale 1ns/10ps
`include "acs_consts.svh"
module acs_conv_timer
(
   input wire logic i_clk, // conversion clock
   input wire logic i_rst_b, // async reset, active low
   input wire logic i_ce, // clock enable
   input wire logic i_load, // start a conversion
   input wire logic i_stab, // include stabilization wait
   input wire logic i_kill, // abort, count dropped
   output logic o_done // one-cycle end of conversion
);
   typedef struct packed
   {
      logic [7:0] cnt;
      logic busy;
      logic done;
   } acs_tmr_t;
   acs_tmr_t s_r, s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (i_load)
      begin
         s_nxt.busy = 1'b1;
         // Stabilized conversion length matches the wait-mode first conversion
         s_nxt.cnt = i_stab ? 8'(`ACS_CONV_CYC + `ACS_STAB_CYC) : `ACS_CONV_CYC; // see R12
      end
      else if (i_kill)
         s_nxt.busy = 1'b0;
      else if (s_r.busy)
      begin
         if (s_r.cnt == 8'h01)
         begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
         end
         s_nxt.cnt = s_r.cnt - 8'h01;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         s_r <= '0;
      else if (i_ce)
         s_r <= s_nxt;
   end

   assign o_done = s_r.done;
endmodule

// >>> acs_sequencer.sv
// Conversion sequencer with APB registers: scan one-shot wait mode and hw-trigger no-wait mode
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "acs_consts.svh"
module acs_sequencer
(
   input wire logic i_clk, // conversion clock, 200 MHz
   input wire logic i_rst_b, // async reset, active low
   input wire logic i_ce, // clock enable, freezes all state
   input wire logic i_psel, // APB select
   input wire logic i_penable, // APB enable
   input wire logic i_pwrite, // APB direction
   input wire logic [7:0] i_paddr, // APB byte address
   input wire logic [31:0] i_pwdata, // APB write data
   output logic [31:0] o_prdata, // APB read data
   output logic o_pready, // APB ready
   output logic o_pslverr, // APB error on unmapped address
   input wire logic i_hw_trig, // hardware trigger pulse
   input wire logic [`ACS_RES_W-1:0] i_adc_data, // analog front end sample
   output logic [2:0] o_adc_chan, // channel fed to the front end
   output logic o_conv_active, // converter sampling
   output logic o_conversion_end_irq // one-cycle end of conversion request
);
   typedef struct packed
   {
      acs_pkg::acs_state_t st;
      logic en;
      logic start;
      logic hwmode;
      logic seq;
      logic [11:0] sel;
      logic [1:0] slot;
      logic [2:0] chan;
      logic [3:0][`ACS_RES_W-1:0] res;
      logic [`ACS_RES_W-1:0] last;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic active;
   } acs_state_r_t;
   acs_state_r_t s_r, s_nxt;

   logic tmr_load, tmr_stab, tmr_kill, done;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [2:0] slot_chan(input logic [11:0] sel, input logic [1:0] slot);
      slot_chan = sel[3*slot +: 3];
   endfunction

   function automatic logic [31:0] zx(input logic [`ACS_RES_W-1:0] v);
      zx = {{(32-`ACS_RES_W){1'b0}}, v};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic acc, fin, wr, rd, ctrl_wr, sel_wr;
   logic start_set, start_clr, trig_ok, converting;

   always_comb
   begin
      acc = i_psel && i_penable && !s_r.pready;
      // Writes land on the edge that completes the transfer, where the master samples ready
      fin = i_psel && i_penable && s_r.pready;
      wr = fin && i_pwrite;
      rd = acc && !i_pwrite;
      ctrl_wr = wr && (i_paddr == `ACS_A_CTRL);
      sel_wr = wr && (i_paddr == `ACS_A_SEL);
      start_set = ctrl_wr && i_pwdata[`ACS_B_START];
      start_clr = ctrl_wr && !i_pwdata[`ACS_B_START];
      converting = (s_r.st == acs_pkg::ACS_CONV) || (s_r.st == acs_pkg::ACS_STAB);
      // Triggers only count in no-wait mode with start armed
      trig_ok = i_hw_trig && s_r.hwmode && s_r.start; // see R22, R10
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      s_nxt = s_r;
      tmr_load = 1'b0;
      tmr_stab = 1'b0;
      tmr_kill = 1'b0;
      s_nxt.irq = 1'b0;
      s_nxt.pready = acc;
      s_nxt.pslverr = 1'b0;

      if (ctrl_wr)
      begin
         s_nxt.en = i_pwdata[`ACS_B_EN];
         s_nxt.start = i_pwdata[`ACS_B_START];
         // Mode bits only change when stopped, software's job in practice
         if (s_r.st == acs_pkg::ACS_STOP)
         begin
            s_nxt.hwmode = i_pwdata[`ACS_B_HWMODE];
            s_nxt.seq = i_pwdata[`ACS_B_SEQ];
         end
      end
      if (sel_wr)
         s_nxt.sel = i_pwdata[11:0];
      if (rd)
      begin
         case (i_paddr)
            `ACS_A_CTRL: s_nxt.prdata = {28'h0, s_r.seq, s_r.hwmode, s_r.start, s_r.en};
            `ACS_A_SEL: s_nxt.prdata = {20'h0, s_r.sel};
            `ACS_A_STAT: s_nxt.prdata = {25'h0, s_r.chan, s_r.st};
            `ACS_A_RES0: s_nxt.prdata = zx(s_r.res[0]);
            `ACS_A_RES1: s_nxt.prdata = zx(s_r.res[1]);
            `ACS_A_RES2: s_nxt.prdata = zx(s_r.res[2]);
            `ACS_A_RES3: s_nxt.prdata = zx(s_r.res[3]);
            `ACS_A_RES: s_nxt.prdata = zx(s_r.last);
            default:
            begin
               s_nxt.prdata = 32'h0;
               s_nxt.pslverr = 1'b1;
            end
         endcase
      end
      else if (acc)
         s_nxt.pslverr = !((i_paddr == `ACS_A_CTRL) || (i_paddr == `ACS_A_SEL) || (i_paddr == `ACS_A_STAT)
            || (i_paddr[7:4] == 4'h1) || (i_paddr == `ACS_A_RES));

      case (s_r.st)
         acs_pkg::ACS_STOP:
         begin
            // Mode bits written by this same access already choose the path
            if (!s_nxt.hwmode && start_set)
            begin
               // Scan starts at slot 0, wait mode adds stabilization
               s_nxt.slot = 2'h0; // see R2, R3
               s_nxt.chan = slot_chan(s_nxt.sel, 2'h0);
               s_nxt.st = acs_pkg::ACS_CONV;
               tmr_load = 1'b1;
               tmr_stab = 1'b1; // see R11
            end
            else if (s_nxt.hwmode && ctrl_wr && i_pwdata[`ACS_B_EN])
               s_nxt.st = acs_pkg::ACS_STBY; // see R13
         end
         acs_pkg::ACS_STBY:
         begin
            if (ctrl_wr && !i_pwdata[`ACS_B_EN])
               s_nxt.st = acs_pkg::ACS_STOP; // see R21
            else if (trig_ok)
            begin
               // Start bit alone only arms; trigger converts one channel
               s_nxt.chan = slot_chan(s_r.sel, 2'h0); // see R15, R16
               s_nxt.st = acs_pkg::ACS_CONV;
               tmr_load = 1'b1;
            end
         end
         acs_pkg::ACS_STAB:
         begin
            // Restart one clock after the abort edge
            s_nxt.st = acs_pkg::ACS_CONV;
            s_nxt.chan = s_r.hwmode ? slot_chan(s_r.sel, 2'h0) : slot_chan(s_r.sel, s_r.slot);
            tmr_load = 1'b1;
            tmr_stab = 1'b1; // see R11, R12, R23
         end
         acs_pkg::ACS_CONV:
         begin
            if (start_clr)
            begin
               tmr_kill = 1'b1;
               s_nxt.st = s_r.hwmode ? acs_pkg::ACS_STBY : acs_pkg::ACS_STOP; // see R9, R20
            end
            else if (start_set || sel_wr || trig_ok)
            begin
               // Partial data dropped; results keep older values
               tmr_kill = 1'b1; // see R7, R8, R18, R19, R24
               s_nxt.slot = 2'h0;
               s_nxt.st = acs_pkg::ACS_STAB;
            end
            else if (done)
            begin
               s_nxt.last = i_adc_data;
               if (!s_r.hwmode)
               begin
                  s_nxt.res[s_r.slot] = i_adc_data; // see R4
                  if (s_r.slot == 2'h3)
                  begin
                     s_nxt.irq = 1'b1; // see R5
                     s_nxt.start = 1'b0; // see R6
                     s_nxt.st = acs_pkg::ACS_STOP;
                  end
                  else
                  begin
                     s_nxt.slot = s_r.slot + 2'h1; // see R3
                     s_nxt.chan = slot_chan(s_r.sel, s_r.slot + 2'h1);
                     tmr_load = 1'b1;
                  end
               end
               else
               begin
                  s_nxt.res[0] = i_adc_data;
                  s_nxt.irq = 1'b1;
                  if (s_r.seq)
                     tmr_load = 1'b1; // see R17
                  else
                     s_nxt.st = acs_pkg::ACS_STBY;
               end
            end
         end
         default: s_nxt.st = acs_pkg::ACS_STOP;
      endcase
      s_nxt.active = (s_nxt.st == acs_pkg::ACS_CONV);
   end

   ////////////////////////////////////////////////////////////////////////////
   acs_conv_timer u_timer
   (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_load(tmr_load),
      .i_stab(tmr_stab),
      .i_kill(tmr_kill),
      .o_done(done)
   );

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         s_r <= '0;
         s_r.st <= acs_pkg::ACS_STOP;
      end
      else if (i_ce)
         s_r <= s_nxt;
   end

   assign o_prdata = s_r.prdata;
   assign o_pready = s_r.pready;
   assign o_pslverr = s_r.pslverr;
   assign o_adc_chan = s_r.chan;
   assign o_conv_active = s_r.active;
   assign o_conversion_end_irq = s_r.irq;

   ////////////////////////////////////////////////////////////////////////////
   a_scan_irq_last: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R5
      (i_ce && !s_r.hwmode && s_r.st == acs_pkg::ACS_CONV && done && !ctrl_wr && !sel_wr) |=>
      (o_conversion_end_irq == ($past(s_r.slot) == 2'h3)))
      else $error("scan interrupt not tied to fourth conversion");
   a_scan_self_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R6
      (i_ce && o_conversion_end_irq && !s_r.hwmode) |-> (!s_r.start && s_r.st == acs_pkg::ACS_STOP))
      else $error("start bit not cleared after scan");
   a_wait_stop_clr: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R9
      (i_ce && !s_r.hwmode && s_r.st == acs_pkg::ACS_CONV && start_clr) |=> (s_r.st == acs_pkg::ACS_STOP))
      else $error("start clear did not stop");
   a_nowait_stby_clr: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R20
      (i_ce && s_r.hwmode && s_r.st == acs_pkg::ACS_CONV && start_clr) |=> (s_r.st == acs_pkg::ACS_STBY))
      else $error("start clear did not return to standby");
   a_abort_restart: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R7
      (i_ce && s_r.st == acs_pkg::ACS_CONV && (start_set || sel_wr) && !start_clr)
      |=> (s_r.st == acs_pkg::ACS_STAB) ##1 (s_r.st == acs_pkg::ACS_CONV || !i_ce))
      else $error("abort did not restart");
   a_abort_keeps_res: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R24
      (i_ce && s_r.st == acs_pkg::ACS_CONV && tmr_kill) |=> $stable(s_r.res))
      else $error("abort altered results");
   a_trig_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R22
      (i_ce && s_r.st == acs_pkg::ACS_STBY && !s_r.start) |=> (s_r.st != acs_pkg::ACS_CONV))
      else $error("trigger accepted with start clear");
   a_wait_no_trig: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R10
      (i_ce && !s_r.hwmode && s_r.st == acs_pkg::ACS_CONV && i_hw_trig && !ctrl_wr && !sel_wr && !done)
      |=> (s_r.st == acs_pkg::ACS_CONV))
      else $error("trigger disturbed wait-mode scan");
   a_enable_stop: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R21
      (i_ce && s_r.st == acs_pkg::ACS_STBY && ctrl_wr && !i_pwdata[`ACS_B_EN]) |=> (s_r.st == acs_pkg::ACS_STOP))
      else $error("enable clear did not stop");

   // APB: one wait state, ready stands for one cycle only
   a_apb_one_wait: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_ce && i_psel && i_penable && !o_pready)
      |=> o_pready)
      else $error("access phase not answered after one wait state");

   a_apb_ready_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_ce && o_pready)
      |=> !o_pready)
      else $error("ready held longer than one cycle");

   a_irq_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_ce && o_conversion_end_irq)
      |=> !o_conversion_end_irq)
      else $error("end interrupt longer than one cycle");

   // An interrupt can only follow a conversion, never stop or standby
   a_irq_after_conv: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_ce && !converting)
      |=> !o_conversion_end_irq)
      else $error("end interrupt without a conversion");

   a_scan_result_store: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R4
      (i_ce && !s_r.hwmode && s_r.st == acs_pkg::ACS_CONV && done && !ctrl_wr && !sel_wr)
      |=> (s_r.res[$past(s_r.slot)] == $past(i_adc_data)))
      else $error("scan result not stored in its slot");

   a_scan_order: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R3
      (i_ce && !s_r.hwmode && s_r.st == acs_pkg::ACS_CONV && done && !ctrl_wr && !sel_wr && s_r.slot != 2'h3)
      |=> (s_r.st == acs_pkg::ACS_CONV && s_r.slot == 2'($past(s_r.slot) + 2'h1)))
      else $error("scan slot order broken");

   a_stby_on_enable: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R13
      (i_ce && s_r.st == acs_pkg::ACS_STOP && ctrl_wr && i_pwdata[`ACS_B_HWMODE] && i_pwdata[`ACS_B_EN])
      |=> (s_r.st == acs_pkg::ACS_STBY))
      else $error("enable in no-wait mode did not reach standby");

   // Start alone must never begin a conversion in no-wait mode
   a_start_arms_only: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R15
      (i_ce && s_r.st == acs_pkg::ACS_STBY && ctrl_wr && i_pwdata[`ACS_B_EN] && !i_hw_trig)
      |=> (s_r.st == acs_pkg::ACS_STBY && !o_conv_active))
      else $error("start bit began a conversion");

   a_trig_converts: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R16
      (i_ce && s_r.hwmode && s_r.start && s_r.st == acs_pkg::ACS_STBY && i_hw_trig && !ctrl_wr)
      |=> (s_r.st == acs_pkg::ACS_CONV && o_adc_chan == $past(s_r.sel[2:0])))
      else $error("trigger did not convert the selected channel");

   a_seq_continue: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R17
      (i_ce && s_r.hwmode && s_r.seq && s_r.st == acs_pkg::ACS_CONV && done && !ctrl_wr && !sel_wr && !i_hw_trig)
      |=> (o_conversion_end_irq && s_r.st == acs_pkg::ACS_CONV && s_r.res[0] == $past(i_adc_data)))
      else $error("sequential conversion did not store and continue");

   a_trig_abort: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R18
      (i_ce && s_r.hwmode && s_r.start && s_r.st == acs_pkg::ACS_CONV && i_hw_trig && !ctrl_wr && !sel_wr)
      |=> (s_r.st == acs_pkg::ACS_STAB) ##1 (s_r.st == acs_pkg::ACS_CONV))
      else $error("trigger did not abort and restart");

   // Abort restarts on the next edge, from slot 0 of the new selection
   a_sel_restart: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R8, R19
      (i_ce && s_r.st == acs_pkg::ACS_CONV && sel_wr)
      |-> ##2 (o_adc_chan == $past(i_pwdata[2:0], 2) && s_r.slot == 2'h0))
      else $error("select write did not restart on the new channel");

   a_restart_conv: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see R23
      (i_ce && s_r.st == acs_pkg::ACS_STAB)
      |=> (s_r.st == acs_pkg::ACS_CONV && o_conv_active))
      else $error("restart did not follow the abort edge");

   // Main scenarios

   c_scan_done: cover property (@(posedge i_clk) o_conversion_end_irq && !s_r.hwmode);
   c_hw_seq: cover property (@(posedge i_clk) o_conversion_end_irq && s_r.hwmode && s_r.seq);
   c_restart: cover property (@(posedge i_clk) s_r.st == acs_pkg::ACS_STAB);
   c_trig_abort: cover property (@(posedge i_clk) s_r.hwmode && s_r.st == acs_pkg::ACS_STAB);
   c_stby_stop: cover property (@(posedge i_clk) s_r.st == acs_pkg::ACS_STBY ##1 s_r.st == acs_pkg::ACS_STOP);
endmodule

// >>> acs_afe_model.sv
// Far-side model: analog front end and hardware trigger source
`timescale 1ns/10ps
`include "acs_consts.svh"
module acs_afe_model
(
   input wire logic i_clk, // conversion clock
   input wire logic i_fire, // bench asks for one trigger pulse
   input wire logic [2:0] i_chan, // channel being converted
   input wire logic i_active, // converter sampling
   output logic o_hw_trig, // trigger pulse, one cycle
   output logic [`ACS_RES_W-1:0] o_adc_data // sample of the selected channel
);
   logic tgl_r;
   initial
   begin
      tgl_r = 1'b0;
      o_hw_trig = 1'b0;
   end
   always @(posedge i_clk)
   begin
      tgl_r <= ~tgl_r;
      o_hw_trig <= i_fire;
   end
   // Outside a conversion the sample is not valid, so it wanders every cycle
   assign o_adc_data = i_active ? {i_chan, 9'h15a} : {12{tgl_r}};
endmodule

// >>> tb_adc_conversion_sequencer.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/10ps
`include "acs_consts.svh"
module tb_adc_conversion_sequencer;
   typedef struct packed {logic [11:0] sel; logic [47:0] res;} acs_row_t;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic fire = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rdat;
   logic pready, pslverr, rerr, trig, active, irq;
   logic [2:0] chan;
   logic [`ACS_RES_W-1:0] adc;
   int fail_count = 0;
   int n_compared = 0;
   int irqs = 0;
   int cyc = 0;
   int t0, n;
   // Scan slot channels beside the four results they should leave
   acs_row_t rows [3] = '{'{12'h688, 48'h75a_55a_35a_15a}, '{12'hfac, 48'hf5a_d5a_b5a_95a},
      '{12'h977, 48'h95a_b5a_d5a_f5a}};

   acs_sequencer DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_hw_trig(trig), .i_adc_data(adc), .o_adc_chan(chan),
      .o_conv_active(active), .o_conversion_end_irq(irq));
   acs_afe_model afe (.i_clk(i_clk), .i_fire(fire), .i_chan(chan), .i_active(active),
      .o_hw_trig(trig), .o_adc_data(adc));

   always #2.5 i_clk = ~i_clk;
   // The interrupt is a one-cycle pulse, so it is counted mid-cycle where it is settled
   always @(negedge i_clk)
      if (irq === 1'b1)
         irqs++;

   task automatic report_and_stop();
      if (fail_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic ok(input logic c, input string m);
      chk({31'h0, c}, 32'h1, m);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      pen <= 1'b1;
      // Ready is sampled at the rising edge that completes the transfer
      @(posedge i_clk);
      while (pready !== 1'b1)
         @(posedge i_clk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic st(input logic [3:0] e);
      apb(1'b0, `ACS_A_STAT, 32'h0);
      chk({28'h0, rdat[3:0]}, {28'h0, e}, "converter state");
   endtask
   task automatic wait_irq(input int goal, input int lim);
      int k;
      k = 0;
      while (irqs < goal && k < lim)
      begin
         @(negedge i_clk);
         k++;
      end
      ok(irqs >= goal, "end interrupt missing");
   endtask
   task automatic res(input acs_row_t r);
      for (int k = 0; k < 4; k++)
      begin
         apb(1'b0, `ACS_A_RES0 + 8'(4 * k), 32'h0);
         chk(rdat, {20'h0, r.res[12*k +: 12]}, "scan result");
      end
   endtask
   task automatic pulse();
      @(posedge i_clk);
      fire <= 1'b1;
      @(posedge i_clk);
      fire <= 1'b0;
   endtask
   task automatic scan_end(input acs_row_t r);
      t0 = cyc;
      n = irqs;
      wait_irq(n + 1, 400);
      ok((cyc - t0) inside {[250:280]}, "scan time");
      repeat (40) @(negedge i_clk);
      chk(irqs, n + 1, "one interrupt per scan");
      res(r);
      apb(1'b0, `ACS_A_CTRL, 32'h0);
      chk(rdat, 32'h0, "start cleared");
      st(4'h1);
   endtask

   initial
   begin
      repeat (4) @(posedge i_clk);
      i_rst_b <= 1'b1;
      st(4'h1);
      apb(1'b0, 8'hfc, 32'h0);
      ok(rerr, "unmapped error");
      chk(rdat, 32'h0, "unmapped data");
      // Enable stays 0 throughout wait mode
      foreach (rows[i])
      begin
         apb(1'b1, `ACS_A_SEL, {20'h0, rows[i].sel});
         apb(1'b1, `ACS_A_CTRL, 32'h2);
         scan_end(rows[i]);
      end
      // Start rewritten mid-scan with a trigger just before it
      apb(1'b1, `ACS_A_SEL, 32'h688);
      apb(1'b1, `ACS_A_CTRL, 32'h2);
      repeat (222) @(posedge i_clk);
      pulse();
      apb(1'b1, `ACS_A_CTRL, 32'h2);
      apb(1'b0, `ACS_A_RES1, 32'h0);
      chk(rdat, 32'hd5a, "aborted slot kept");
      scan_end(rows[0]);
      // Channel select rewritten mid-scan
      apb(1'b1, `ACS_A_CTRL, 32'h2);
      repeat (222) @(posedge i_clk);
      apb(1'b1, `ACS_A_SEL, 32'hfac);
      scan_end(rows[1]);
      // Start cleared mid-scan
      apb(1'b1, `ACS_A_CTRL, 32'h2);
      repeat (100) @(posedge i_clk);
      apb(1'b1, `ACS_A_CTRL, 32'h0);
      n = irqs;
      st(4'h1);
      repeat (300) @(posedge i_clk);
      chk(irqs, n, "no interrupt after stop");
      // Hardware-trigger no-wait mode, single conversion
      apb(1'b1, `ACS_A_CTRL, 32'h5);
      st(4'h2);
      apb(1'b1, `ACS_A_SEL, 32'h3);
      repeat (204) @(posedge i_clk);
      pulse();
      repeat (40) @(posedge i_clk);
      st(4'h2);
      apb(1'b1, `ACS_A_CTRL, 32'h7);
      repeat (40) @(posedge i_clk);
      st(4'h2);
      chk(irqs, n, "no conversion before trigger");
      pulse();
      wait_irq(n + 1, 300);
      apb(1'b0, `ACS_A_RES, 32'h0);
      chk(rdat, 32'h75a, "triggered result");
      apb(1'b1, `ACS_A_CTRL, 32'h4);
      st(4'h1);
      // Sequential conversions, then aborts
      apb(1'b1, `ACS_A_CTRL, 32'hd);
      apb(1'b1, `ACS_A_CTRL, 32'hf);
      n = irqs;
      pulse();
      wait_irq(n + 1, 300);
      wait_irq(n + 3, 60);
      pulse();
      repeat (3) @(posedge i_clk);
      t0 = cyc;
      n = irqs;
      wait_irq(n + 1, 300);
      ok((cyc - t0) inside {[195:240]}, "trigger abort restart");
      apb(1'b1, `ACS_A_SEL, 32'h5);
      repeat (2) @(posedge i_clk);
      n = irqs;
      wait_irq(n + 1, 300);
      apb(1'b0, `ACS_A_RES, 32'h0);
      chk(rdat, 32'hb5a, "new channel result");
      apb(1'b1, `ACS_A_CTRL, 32'hd);
      n = irqs;
      st(4'h2);
      repeat (250) @(posedge i_clk);
      chk(irqs, n, "no conversion after start clear");
      apb(1'b1, `ACS_A_CTRL, 32'h0);
      st(4'h1);
      // Reset in mid-scan, after slot 0 has stored, clears state and results
      apb(1'b1, `ACS_A_CTRL, 32'h2);
      repeat (230) @(posedge i_clk);
      i_rst_b <= 1'b0;
      repeat (4) @(posedge i_clk);
      i_rst_b <= 1'b1;
      n = irqs;
      st(4'h1);
      apb(1'b0, `ACS_A_RES0, 32'h0);
      chk(rdat, 32'h0, "result after reset");
      repeat (300) @(posedge i_clk);
      chk(irqs, n, "no interrupt after reset");
      report_and_stop();
   end
endmodule
